//--- bench/ldr_host_model.sv
/*
 * host model: drives the hardware reset pin and the decoded setting writes.
 * assumes the bench calls its tasks and that inputs change at the falling edge.
 */
`timescale 1ns/1ps
module ldr_host_model #(
	parameter int RST_LOW_CYC = 400,
	parameter int HOLD_CYC = 40
) (
	// clock
	input wire logic ref_clk,
	// host side signals
	output logic hw_reset_pin_n,
	output logic sw_reset_cmd,
	output ldr_pkg::ldr_wr_e cfg_wr_sel,
	output logic [7:0] cfg_wr_data
);
	// cycles with the pin low, cycles since it rose
	int low_cnt = 0;
	int since_rise = 0;

	initial begin
		hw_reset_pin_n = 1'b1;
		sw_reset_cmd = 1'b0;
		cfg_wr_sel = ldr_pkg::LDR_WR_NONE;
		cfg_wr_data = 8'h00;
	end

	// counts of pin low time and quiet time after release
	always @(negedge ref_clk) begin
		low_cnt <= hw_reset_pin_n ? 0 : low_cnt + 1;
		since_rise <= !hw_reset_pin_n ? 0 : (since_rise < HOLD_CYC ? since_rise + 1 : since_rise);
	end

	// pull the reset pin low
	task automatic pin_low();
		@(negedge ref_clk);
		hw_reset_pin_n = 1'b0;
	endtask

	task automatic pin_high();
		while (low_cnt < RST_LOW_CYC) @(negedge ref_clk);
		hw_reset_pin_n = 1'b1;
	endtask

	task automatic write(input ldr_pkg::ldr_wr_e sel, input logic [7:0] dat);
		@(negedge ref_clk);
		while (hw_reset_pin_n && since_rise < HOLD_CYC) @(negedge ref_clk);
		cfg_wr_sel = sel;
		cfg_wr_data = dat;
		@(negedge ref_clk);
		cfg_wr_sel = ldr_pkg::LDR_WR_NONE;
	endtask

	// one-cycle software reset pulse
	task automatic sw_reset();
		@(negedge ref_clk);
		sw_reset_cmd = 1'b1;
		@(negedge ref_clk);
		sw_reset_cmd = 1'b0;
	endtask
endmodule

//--- bench/testbench.sv
/*
 * self-checking bench of the reset and initialisation sequencer.
 * assumes the host model above; short busy count for simulation speed.
 */
`timescale 1ns/1ps
module testbench;
	localparam int BUSY = 4;
	// settings after a hardware reset, field by field
	localparam logic [31:0] CFG_DEF = {3'h0, 2'h0, 1'b1, 2'h0, 7'h00, 4'hF, 2'h2,
		2'h0, 1'b0, 7'h00, 1'b0};
	typedef struct packed {ldr_pkg::ldr_wr_e sel; logic [7:0] dat; logic [7:0] fld;} ldr_row_s;
	localparam ldr_row_s ROWS [0:15] = '{
		'{ldr_pkg::LDR_WR_DISPLAY, 8'h01, 8'h01}, '{ldr_pkg::LDR_WR_SEG_ORDER, 8'h01, 8'h01},
		'{ldr_pkg::LDR_WR_INVERSE, 8'h01, 8'h01}, '{ldr_pkg::LDR_WR_WHOLE_ON, 8'h03, 8'h03},
		'{ldr_pkg::LDR_WR_POWER_SAVE, 8'h00, 8'h00}, '{ldr_pkg::LDR_WR_PAGE, 8'h03, 8'h03},
		'{ldr_pkg::LDR_WR_COLUMN, 8'h7F, 8'h7F}, '{ldr_pkg::LDR_WR_CONTRAST, 8'hF5, 8'h05},
		'{ldr_pkg::LDR_WR_DUTY, 8'h00, 8'h00}, '{ldr_pkg::LDR_WR_DUTY, 8'h03, 8'h00},
		'{ldr_pkg::LDR_WR_DUTY, 8'h01, 8'h01}, '{ldr_pkg::LDR_WR_PWM_PHASE, 8'h02, 8'h02},
		'{ldr_pkg::LDR_WR_PWM_EN, 8'h01, 8'h01}, '{ldr_pkg::LDR_WR_PWM_VALUE, 8'h7F, 8'h7F},
		'{ldr_pkg::LDR_WR_PORT3_SEL, 8'h01, 8'h01}, '{ldr_pkg::LDR_WR_PORT3_SEL, 8'h00, 8'h00}};
	// clock, reset and bench driven inputs
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_detect_signal = 1'b0;
	logic key_result_valid = 1'b0;
	logic [ldr_pkg::KEY_W-1:0] key_result = '0;
	// host driven inputs
	logic hw_reset_pin_n, sw_reset_cmd;
	ldr_pkg::ldr_wr_e cfg_wr_sel;
	logic [7:0] cfg_wr_data;
	// design outputs
	logic internal_reset, busy, osc_enable, serial_accept, serial_shift_clear, key_scan_enable;
	ldr_pkg::ldr_cfg_s cfg;
	logic [ldr_pkg::KEY_W-1:0] key_read_data;
	logic drivers_force_low, display_blank, port3_or_scan0_pin, serial_data_io_oe;
	logic [ldr_pkg::GPO_W-1:0] general_output_ports;
	logic [ldr_pkg::SCAN_W-1:0] key_scan_drive_pins;
	int miscompares = 0;
	int cmp_count = 0;

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	ldr_reset_init #(.BUSY_CYCLES(BUSY)) u_ldr_reset_init (.ref_clk(ref_clk), .rst_n(rst_n),
		.supply_detect_signal(supply_detect_signal), .hw_reset_pin_n(hw_reset_pin_n),
		.sw_reset_cmd(sw_reset_cmd), .cfg_wr_sel(cfg_wr_sel), .cfg_wr_data(cfg_wr_data),
		.key_result_valid(key_result_valid), .key_result(key_result),
		.internal_reset(internal_reset), .busy(busy), .osc_enable(osc_enable),
		.serial_accept(serial_accept), .serial_shift_clear(serial_shift_clear),
		.key_scan_enable(key_scan_enable), .cfg(cfg), .key_read_data(key_read_data),
		.drivers_force_low(drivers_force_low), .display_blank(display_blank),
		.general_output_ports(general_output_ports), .port3_or_scan0_pin(port3_or_scan0_pin),
		.key_scan_drive_pins(key_scan_drive_pins), .serial_data_io_oe(serial_data_io_oe));

	ldr_host_model #(.RST_LOW_CYC(400), .HOLD_CYC(BUSY + 4)) u_ldr_host_model (.ref_clk(ref_clk),
		.hw_reset_pin_n(hw_reset_pin_n), .sw_reset_cmd(sw_reset_cmd),
		.cfg_wr_sel(cfg_wr_sel), .cfg_wr_data(cfg_wr_data));

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// pick one setting out of the carrier
	function automatic logic [7:0] get_field(input ldr_pkg::ldr_cfg_s c, input ldr_pkg::ldr_wr_e s);
		case (s)
			ldr_pkg::LDR_WR_DISPLAY: return 8'(c.display_on);
			ldr_pkg::LDR_WR_SEG_ORDER: return 8'(c.seg_reverse);
			ldr_pkg::LDR_WR_INVERSE: return 8'(c.inverse);
			ldr_pkg::LDR_WR_WHOLE_ON: return 8'(c.whole_on);
			ldr_pkg::LDR_WR_POWER_SAVE: return 8'(c.power_save);
			ldr_pkg::LDR_WR_PAGE: return 8'(c.page);
			ldr_pkg::LDR_WR_COLUMN: return 8'(c.column);
			ldr_pkg::LDR_WR_CONTRAST: return 8'(c.contrast_level_register);
			ldr_pkg::LDR_WR_DUTY: return 8'(c.duty);
			ldr_pkg::LDR_WR_PWM_PHASE: return 8'(c.pwm_phase);
			ldr_pkg::LDR_WR_PWM_EN: return 8'(c.port_pwm_output_enable);
			ldr_pkg::LDR_WR_PWM_VALUE: return 8'(c.pwm_value);
			ldr_pkg::LDR_WR_PORT3_SEL: return 8'(c.port3_scan_sel);
			default: return 8'h00;
		endcase
	endfunction

	// every output but busy while reset is in force
	task automatic check_rst();
		check(internal_reset, 1'b1);
		check(osc_enable, 1'b0);
		check({display_blank, serial_accept}, 2'h3);
		check(key_scan_enable, 1'b0);
		check({drivers_force_low, general_output_ports, key_scan_drive_pins}, 8'h8F);
		check(port3_or_scan0_pin, 1'b0);
		check({serial_data_io_oe, key_read_data}, 26'h1FFFFFF);
		check(serial_shift_clear, 1'b1);
		check(cfg, CFG_DEF);
	endtask

	// wait out reset, measure busy, then check run state
	task automatic wait_run();
		int n;
		n = 0;
		while (internal_reset === 1'b1 && n < 1000) begin
			@(negedge ref_clk);
			n++;
		end
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		check(n, BUSY);
		check({internal_reset, osc_enable, key_scan_enable}, 3'h3);
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (6000) @(posedge ref_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (3) @(negedge ref_clk);
		check_rst();
		rst_n = 1'b1;
		wait_run();
		// table of setting writes
		foreach (ROWS[i]) begin
			u_ldr_host_model.write(ROWS[i].sel, ROWS[i].dat);
			check(get_field(cfg, ROWS[i].sel), ROWS[i].fld);
		end
		// pin levels follow the settings one cycle later
		@(negedge ref_clk);
		check({display_blank, general_output_ports, port3_or_scan0_pin}, 5'h0F);
		u_ldr_host_model.write(ldr_pkg::LDR_WR_PWM_EN, 8'h00);
		@(negedge ref_clk);
		check({general_output_ports, port3_or_scan0_pin}, 4'h0);
		u_ldr_host_model.write(ldr_pkg::LDR_WR_PORT3_SEL, 8'h01);
		@(negedge ref_clk);
		check(port3_or_scan0_pin, 1'b1);
		// software reset leaves display controls alone
		u_ldr_host_model.sw_reset();
		check(cfg, {3'h7, 2'h3, 1'b0, 2'h0, 7'h00, 4'hF, 2'h2, 2'h0, 1'b0, 7'h00, 1'b0});
		// key result captured, then lost through a pin reset
		key_result = 25'h0A5A5A5;
		key_result_valid = 1'b1;
		@(negedge ref_clk);
		key_result_valid = 1'b0;
		check(key_read_data, 25'h0A5A5A5);
		// move addresses, contrast, duty and pwm off their defaults again
		for (int i = 5; i < 15; i++) u_ldr_host_model.write(ROWS[i].sel, ROWS[i].dat);
		u_ldr_host_model.pin_low();
		repeat (2) @(negedge ref_clk);
		check_rst();
		check(cfg.page, 2'h0);
		check({cfg.contrast_level_register, cfg.duty}, 6'h3E);
		check({cfg.pwm_phase, cfg.port_pwm_output_enable, cfg.port3_scan_sel}, 4'h0);
		u_ldr_host_model.write(ldr_pkg::LDR_WR_CONTRAST, 8'h03);
		check(cfg, CFG_DEF);
		u_ldr_host_model.pin_high();
		wait_run();
		check(key_read_data, 25'h0);
		// supply detector forces reset with the pin high
		@(negedge ref_clk);
		supply_detect_signal = 1'b1;
		repeat (2) @(negedge ref_clk);
		check_rst();
		supply_detect_signal = 1'b0;
		wait_run();
		end_of_test();
	end
endmodule

//--- include/ldr_pkg.sv
/*
 * shared constants and types of the display driver reset and initialisation unit:
 * timing counts, default settings, setting-write selectors and the settings carrier.
 * assumes a single 40 MHz ref_clk; nothing else in the chip imports from here.
 */
package ldr_pkg;

	// clock and busy interval after the reset pin rises
	localparam int CLK_PERIOD_PS = 25000;
	localparam int BUSY_TIME_NS = 1000;
	localparam int BUSY_TIME_PS = BUSY_TIME_NS * 1000;
	// longest time rounds down to whole cycles, never under one
	localparam int BUSY_CYC_RAW = BUSY_TIME_PS / CLK_PERIOD_PS;
	localparam int BUSY_CYC = (BUSY_CYC_RAW < 1) ? 1 : BUSY_CYC_RAW;

	// field widths
	localparam int PAGE_W = 2;
	localparam int COL_W = 7;
	localparam int CONTRAST_W = 4;
	localparam int PWM_W = 7;
	localparam int KEY_W = 25;
	localparam int GPO_W = 3;
	localparam int SCAN_W = 4;

	// duty ratio encodings
	typedef enum logic [1:0] {
		LDR_DUTY_1_8 = 2'h0,
		LDR_DUTY_1_9 = 2'h1,
		LDR_DUTY_1_10 = 2'h2
	} ldr_duty_e;

	// which setting a host write targets
	typedef enum logic [3:0] {
		LDR_WR_NONE = 4'h0,
		LDR_WR_DISPLAY = 4'h1,
		LDR_WR_SEG_ORDER = 4'h2,
		LDR_WR_INVERSE = 4'h3,
		LDR_WR_WHOLE_ON = 4'h4,
		LDR_WR_POWER_SAVE = 4'h5,
		LDR_WR_PAGE = 4'h6,
		LDR_WR_COLUMN = 4'h7,
		LDR_WR_CONTRAST = 4'h8,
		LDR_WR_DUTY = 4'h9,
		LDR_WR_PWM_PHASE = 4'hA,
		LDR_WR_PWM_EN = 4'hB,
		LDR_WR_PWM_VALUE = 4'hC,
		LDR_WR_PORT3_SEL = 4'hD
	} ldr_wr_e;

	// control settings held by the unit
	typedef struct packed {
		logic display_on;
		logic seg_reverse;
		logic inverse;
		logic [1:0] whole_on;
		logic power_save;
		logic [PAGE_W-1:0] page;
		logic [COL_W-1:0] column;
		logic [CONTRAST_W-1:0] contrast_level_register;
		ldr_duty_e duty;
		logic [1:0] pwm_phase;
		logic port_pwm_output_enable;
		logic [PWM_W-1:0] pwm_value;
		logic port3_scan_sel;
	} ldr_cfg_s;

	// default values
	localparam logic [CONTRAST_W-1:0] CONTRAST_RST = 4'hF;
	localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
	localparam logic [COL_W-1:0] COL_RST = 7'h00;
	localparam logic [1:0] PWM_PHASE_RST = 2'h0;
	localparam logic [PWM_W-1:0] PWM_VALUE_RST = 7'h00;
	localparam logic [KEY_W-1:0] KEY_CLEAR = 25'h0000000;
	localparam logic [KEY_W-1:0] KEY_ALL_ONES = 25'h1FFFFFF;
	localparam logic [GPO_W-1:0] GPO_RST = 3'h0;
	localparam logic [SCAN_W-1:0] SCAN_IDLE = 4'hF;

	localparam ldr_cfg_s CFG_RST = '{
		display_on: 1'b0,
		seg_reverse: 1'b0,
		inverse: 1'b0,
		whole_on: 2'h0,
		power_save: 1'b1,
		page: PAGE_RST,
		column: COL_RST,
		contrast_level_register: CONTRAST_RST,
		duty: LDR_DUTY_1_10,
		pwm_phase: PWM_PHASE_RST,
		port_pwm_output_enable: 1'b0,
		pwm_value: PWM_VALUE_RST,
		port3_scan_sel: 1'b0
	};

	// sequencer states, gray along reset -> busy -> run
	typedef enum logic [1:0] {
		LDR_ST_RESET = 2'b00,
		LDR_ST_BUSY = 2'b01,
		LDR_ST_RUN = 2'b11
	} ldr_state_e;

endpackage

//--- rtl/ldr_busy_timer.sv
/*
 * busy interval timer: counts a fixed number of ref_clk cycles after a start pulse
 * and raises done for one cycle at the end. assumes start arrives while idle.
 */
`timescale 1ns/1ps
module ldr_busy_timer #(
	parameter int CYCLES = ldr_pkg::BUSY_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic abort,
	// status
	output logic running,
	output logic done
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count_reg; // cycles elapsed in the interval

	// counter and running flag
	always_ff @(posedge ref_clk) begin
		if (!rst_n || abort) begin
			count_reg <= '0;
			running <= 1'b0;
			done <= 1'b0;
		end else if (start && !running) begin
			// the start edge already counts as the first busy cycle
			count_reg <= CW'(1);
			running <= 1'b1;
			done <= 1'b0;
		end else if (running && count_reg >= LAST) begin
			// interval expired
			running <= 1'b0;
			done <= 1'b1;
		end else begin
			count_reg <= running ? count_reg + CW'(1) : count_reg;
			done <= 1'b0;
		end
	end

endmodule

//--- rtl/ldr_reset_init.sv
/*
 * reset and initialisation sequencer of a bitmap display driver with key scan.
 * holds control settings, forces pin levels while in reset, and times the busy
 * interval after the hardware reset pin rises. assumes all inputs are synchronous
 * to ref_clk and that the serial decoder presents one setting write per pulse.
 */
//
// Behaviour
// - low supply detect forces internal reset
// - oscillator stopped while reset active
// - display blank, serial link still accepted
// - key scan off, key buffer cleared
// - segments, commons, ports low; scan high
// - port three pin drives low in reset
// - data pin released; key reads all ones
// - busy one microsecond after pin rises
// - software reset restores only listed settings
// - clear shift register, display off, power save
// - normal order, non-inverted, whole-on off
// - page and column addresses go zero
// - contrast all ones, one-in-ten duty
// - PWM phase and frequency cleared
// - PWM off and zero, port three selected
`timescale 1ns/1ps
module ldr_reset_init #(
	parameter int BUSY_CYCLES = ldr_pkg::BUSY_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// reset sources
	input wire logic supply_detect_signal,
	input wire logic hw_reset_pin_n,
	// host setting writes from the serial decoder
	input wire logic sw_reset_cmd,
	input wire ldr_pkg::ldr_wr_e cfg_wr_sel,
	input wire logic [7:0] cfg_wr_data,
	// key scan result from the scan engine
	input wire logic key_result_valid,
	input wire logic [ldr_pkg::KEY_W-1:0] key_result,
	// sequencer status
	output logic internal_reset,
	output logic busy,
	output logic osc_enable,
	output logic serial_accept,
	output logic serial_shift_clear,
	output logic key_scan_enable,
	// settings
	output ldr_pkg::ldr_cfg_s cfg,
	// key data seen by the host
	output logic [ldr_pkg::KEY_W-1:0] key_read_data,
	// pin control
	output logic drivers_force_low,
	output logic display_blank,
	output logic [ldr_pkg::GPO_W-1:0] general_output_ports,
	output logic port3_or_scan0_pin,
	output logic [ldr_pkg::SCAN_W-1:0] key_scan_drive_pins,
	output logic serial_data_io_oe
);
	ldr_pkg::ldr_state_e state_reg; // sequencer state
	ldr_pkg::ldr_state_e state_next;
	logic reset_src; // either reset source active
	logic timer_running;
	logic timer_done;
	logic [ldr_pkg::KEY_W-1:0] key_buf_reg; // key data buffer
	logic in_reset; // reset or busy entered at the next edge

	assign reset_src = supply_detect_signal || !hw_reset_pin_n;
	assign in_reset = (state_next != ldr_pkg::LDR_ST_RUN);

	// busy interval timer, started when both reset sources release
	ldr_busy_timer #(
		.CYCLES(BUSY_CYCLES)
	) u_busy (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(state_reg == ldr_pkg::LDR_ST_RESET && !reset_src),
		.abort(reset_src),
		.running(timer_running),
		.done(timer_done)
	);

	// next state of the sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			// held until both sources release
			ldr_pkg::LDR_ST_RESET: begin
				if (!reset_src) begin
					state_next = ldr_pkg::LDR_ST_BUSY;
				end
			end
			ldr_pkg::LDR_ST_BUSY: begin
				if (reset_src) begin
					state_next = ldr_pkg::LDR_ST_RESET;
				end else if (timer_done) begin
					state_next = ldr_pkg::LDR_ST_RUN;
				end
			end
			// normal operation
			ldr_pkg::LDR_ST_RUN: begin
				if (reset_src) begin
					state_next = ldr_pkg::LDR_ST_RESET;
				end
			end
			default: begin
				state_next = ldr_pkg::LDR_ST_RESET;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= ldr_pkg::LDR_ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// sequencer status outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			internal_reset <= 1'b1;
			busy <= 1'b0;
			osc_enable <= 1'b0;
			key_scan_enable <= 1'b0;
			serial_shift_clear <= 1'b1;
		end else begin
			// asserted by the next edge, released in step with state
			internal_reset <= (state_next == ldr_pkg::LDR_ST_RESET);
			busy <= (state_next == ldr_pkg::LDR_ST_BUSY);
			osc_enable <= !in_reset;
			key_scan_enable <= !in_reset;
			serial_shift_clear <= (state_next == ldr_pkg::LDR_ST_RESET);
		end
	end

	// serial link stays open, even during reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			serial_accept <= 1'b1;
		end else begin
			serial_accept <= 1'b1;
		end
	end

	// settings register: defaults on reset, partial restore on software reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n || in_reset) begin
			cfg <= ldr_pkg::CFG_RST;
		end else if (sw_reset_cmd) begin
			// only addresses, contrast, duty, pwm and port select
			cfg.page <= ldr_pkg::CFG_RST.page;
			cfg.column <= ldr_pkg::CFG_RST.column;
			cfg.contrast_level_register <= ldr_pkg::CFG_RST.contrast_level_register;
			cfg.duty <= ldr_pkg::CFG_RST.duty;
			cfg.pwm_phase <= ldr_pkg::CFG_RST.pwm_phase;
			cfg.port_pwm_output_enable <= ldr_pkg::CFG_RST.port_pwm_output_enable;
			cfg.pwm_value <= ldr_pkg::CFG_RST.pwm_value;
			cfg.port3_scan_sel <= ldr_pkg::CFG_RST.port3_scan_sel;
		end else begin
			// host setting writes
			unique case (cfg_wr_sel)
				ldr_pkg::LDR_WR_NONE: begin
				end
				ldr_pkg::LDR_WR_DISPLAY: cfg.display_on <= cfg_wr_data[0];
				ldr_pkg::LDR_WR_SEG_ORDER: cfg.seg_reverse <= cfg_wr_data[0];
				ldr_pkg::LDR_WR_INVERSE: cfg.inverse <= cfg_wr_data[0];
				ldr_pkg::LDR_WR_WHOLE_ON: cfg.whole_on <= cfg_wr_data[1:0];
				ldr_pkg::LDR_WR_POWER_SAVE: cfg.power_save <= cfg_wr_data[0];
				ldr_pkg::LDR_WR_PAGE: cfg.page <= cfg_wr_data[ldr_pkg::PAGE_W-1:0];
				ldr_pkg::LDR_WR_COLUMN: cfg.column <= cfg_wr_data[ldr_pkg::COL_W-1:0];
				ldr_pkg::LDR_WR_CONTRAST: begin
					cfg.contrast_level_register <= cfg_wr_data[ldr_pkg::CONTRAST_W-1:0];
				end
				ldr_pkg::LDR_WR_DUTY: begin
					// illegal code keeps the current duty
					if (cfg_wr_data[1:0] != 2'h3) begin
						cfg.duty <= ldr_pkg::ldr_duty_e'(cfg_wr_data[1:0]);
					end
				end
				ldr_pkg::LDR_WR_PWM_PHASE: cfg.pwm_phase <= cfg_wr_data[1:0];
				ldr_pkg::LDR_WR_PWM_EN: cfg.port_pwm_output_enable <= cfg_wr_data[0];
				ldr_pkg::LDR_WR_PWM_VALUE: cfg.pwm_value <= cfg_wr_data[ldr_pkg::PWM_W-1:0];
				ldr_pkg::LDR_WR_PORT3_SEL: cfg.port3_scan_sel <= cfg_wr_data[0];
				default: begin
				end
			endcase
		end
	end

	// key data buffer
	always_ff @(posedge ref_clk) begin
		if (!rst_n || in_reset) begin
			key_buf_reg <= ldr_pkg::KEY_CLEAR;
		end else if (key_result_valid) begin
			key_buf_reg <= key_result;
		end
	end

	// key data as the host reads it
	always_ff @(posedge ref_clk) begin
		if (!rst_n || in_reset) begin
			// released data line reads as all ones
			key_read_data <= ldr_pkg::KEY_ALL_ONES;
		end else begin
			key_read_data <= key_result_valid ? key_result : key_buf_reg;
		end
	end

	// pin levels
	always_ff @(posedge ref_clk) begin
		if (!rst_n || in_reset) begin
			// drivers and ports low, scan lines high
			drivers_force_low <= 1'b1;
			general_output_ports <= ldr_pkg::GPO_RST;
			key_scan_drive_pins <= ldr_pkg::SCAN_IDLE;
			// shared pin as general output, low
			port3_or_scan0_pin <= 1'b0;
			serial_data_io_oe <= 1'b0;
			display_blank <= 1'b1;
		end else begin
			drivers_force_low <= 1'b0;
			// steady port level follows the pwm enable; modulation lies outside
			general_output_ports <= {ldr_pkg::GPO_W{cfg.port_pwm_output_enable}};
			key_scan_drive_pins <= ldr_pkg::SCAN_IDLE;
			port3_or_scan0_pin <= cfg.port3_scan_sel ? 1'b1
				: cfg.port_pwm_output_enable;
			serial_data_io_oe <= 1'b0;
			display_blank <= !cfg.display_on;
		end
	end

	// a reset source is seen by the next edge
	reset_seen_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		reset_src |=> internal_reset)
		else $error("reset source not followed by internal reset");

	// supply detector alone resets
	supply_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		supply_detect_signal |=> internal_reset && !osc_enable)
		else $error("supply detect did not reset");

	// oscillator never runs while reset or busy
	osc_stopped_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(internal_reset || busy) |-> !osc_enable)
		else $error("oscillator enabled during reset");

	// cycles spent busy, helper for the interval check
	logic [15:0] busy_cnt_reg;
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !busy) begin
			busy_cnt_reg <= '0;
		end else if (busy_cnt_reg != '1) begin
			busy_cnt_reg <= busy_cnt_reg + 16'h0001;
		end
	end

	// busy lasts exactly the interval after the pin rises
	busy_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		($fell(busy) && !internal_reset) |-> int'(busy_cnt_reg) == BUSY_CYCLES)
		else $error("busy interval has wrong length");

	// run reached within 60 cycles of eight quiet ones once sources are quiet
	busy_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		($fell(internal_reset) && !reset_src) ##1 (!reset_src) [*8]
		|-> ##[1:60] (!busy || reset_src))
		else $error("busy did not end");

	// pins at their reset levels
	pin_levels_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		internal_reset |-> drivers_force_low && general_output_ports == 3'h0
		&& key_scan_drive_pins == 4'hF && !port3_or_scan0_pin && !serial_data_io_oe)
		else $error("pin levels wrong in reset");

	// key data and scanning in reset
	key_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		internal_reset |=> !key_scan_enable && key_read_data == 25'h1FFFFFF)
		else $error("key state wrong in reset");

	// defaults held after reset
	cfg_default_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		internal_reset |-> cfg.contrast_level_register == 4'hF
		&& cfg.duty == ldr_pkg::LDR_DUTY_1_10 && cfg.power_save && !cfg.display_on)
		else $error("defaults not loaded");

	// software reset leaves display and power save untouched
	sw_partial_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sw_reset_cmd && !in_reset) |=> cfg.column == 7'h00 && cfg.page == 2'h0
		&& $stable(cfg.display_on) && $stable(cfg.power_save) && $stable(cfg.inverse))
		else $error("software reset wrong scope");

endmodule
